// >>> verilog/lqta_pkg.sv
// Package: register map, field layout and types for threshold access
package lqta_pkg;
  localparam logic [4:0] LQTA_ADDR_ACCESS  = 5'h1e;
  localparam int         LQTA_RSVD_HI      = 15;
  localparam int         LQTA_SAMPLE_BIT   = 13;
  localparam int         LQTA_WSTROBE_BIT  = 12;
  localparam int         LQTA_PSEL_HI      = 11;
  localparam int         LQTA_PSEL_LO      = 9;
  localparam int         LQTA_BSEL_BIT     = 8;
  localparam int         LQTA_DATA_HI      = 7;
  localparam int         LQTA_NUM_PARAMS   = 5;
  localparam int         LQTA_NUM_ENTRIES  = 10;
  localparam logic [2:0] LQTA_PSEL_RESET   = 3'h0;
  localparam logic [7:0] LQTA_DATA_RESET   = 8'h00;
  localparam logic [7:0] LQTA_THR_LO_RESET = 8'h00;
  localparam logic [7:0] LQTA_THR_HI_RESET = 8'hff;
  localparam logic       LQTA_WSTROBE_READ = 1'b0;

  // Parameter selector encodings
  typedef enum logic [2:0] {
    LQTA_P_EQ_COEF   = 3'h0,
    LQTA_P_DIG_GAIN  = 3'h1,
    LQTA_P_BLW_COMP  = 3'h2,
    LQTA_P_FREQ_OFS  = 3'h3,
    LQTA_P_FREQ_CTRL = 3'h4
  } lqta_param_t;

  // Register bus request bundle
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } lqta_req_t;

  // Current adapted values from the DSP, one byte each
  typedef struct packed {
    logic [7:0] freq_ctrl;
    logic [7:0] freq_ofs;
    logic [7:0] blw_comp;
    logic [7:0] dig_gain;
    logic [7:0] eq_coef;
  } lqta_params_t;
endpackage

// >>> verilog/lqta_threshold_access.sv
// Link quality threshold access register and threshold store
// How it works
// - Threshold writes are dropped while the device is powered down.
// - Bits 15:14 ignore writes and read zero.
// - Writing 1 to the sample trigger captures the current parameter value.
// - The parameter sampled is the one named by the parameter select field.
// - The write strobe updates the entry chosen by parameter and bound.
// - The stored value is the threshold value field of the same register.
// - The write strobe bit always reads a fixed constant.
// - Parameter select is bits 11:9, reset zero, encoding five parameters.
// - One select field serves both sampling and threshold access.
// - Bound select 0 picks the low threshold, 1 the high.
// - Entry index is parameter select followed by bound select.
// - A sampled value crossing an enabled threshold raises the monitor flag.
//
// Register word at the access offset, as software sees it:
//   15:14 reserved, read zero, writes dropped
//   13    sample mode; while set the low byte tracks the live parameter
//   12    threshold write strobe; acts on the write, reads zero
//   11:9  parameter select; codes 5 to 7 have no entries behind them
//   8     bound select, low or high threshold
//   7:0   threshold value on write; sample or threshold on read
// Limitation: in sample mode the read byte is a cycle or two old, not a
// snapshot held from the trigger write.
// Thresholds reset to full scale so every check starts switched off.
//
// The implementer's own choice: the plain strobed port.
module lqta_threshold_access
  import lqta_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire lqta_req_t    req,
  output logic [15:0]       rdata,
  input  wire logic         powered_down,
  input  wire logic         monitor_enable,
  input  wire lqta_params_t params,
  output logic              threshold_event,
  output logic              write_pulse
);

  logic [2:0]        psel;
  logic              bsel;
  logic              sample_mode;
  logic [DATA_W-1:0] data_field;
  logic [DATA_W-1:0] sampled;
  logic [DATA_W-1:0] thr_lo [LQTA_NUM_PARAMS];
  logic [DATA_W-1:0] thr_hi [LQTA_NUM_PARAMS];
  logic [DATA_W-1:0] cur_param;
  logic [DATA_W-1:0] sel_thr;
  logic              wr_hit;
  logic              strobe_req;
  logic              sample_req;
  logic [2:0]        wr_psel;
  logic              wr_bsel;
  logic              psel_valid;
  logic              thr_we;
  logic [15:0]       read_word;

  assign wr_hit     = req.wr && (req.addr == LQTA_ADDR_ACCESS);
  assign strobe_req = wr_hit && req.wdata[LQTA_WSTROBE_BIT];
  assign sample_req = wr_hit && req.wdata[LQTA_SAMPLE_BIT];
  assign wr_psel    = req.wdata[LQTA_PSEL_HI:LQTA_PSEL_LO];
  assign wr_bsel    = req.wdata[LQTA_BSEL_BIT];
  assign psel_valid = (psel < 3'(LQTA_NUM_PARAMS));

  // Accepted threshold write; power-down and unused codes both refuse it
  assign thr_we     = strobe_req && !powered_down &&
                      (wr_psel < 3'(LQTA_NUM_PARAMS));

  // Live parameter chosen by the select field
  always_comb begin
    case (lqta_param_t'(psel))
      LQTA_P_EQ_COEF:   cur_param = params.eq_coef;
      LQTA_P_DIG_GAIN:  cur_param = params.dig_gain;
      LQTA_P_BLW_COMP:  cur_param = params.blw_comp;
      LQTA_P_FREQ_OFS:  cur_param = params.freq_ofs;
      LQTA_P_FREQ_CTRL: cur_param = params.freq_ctrl;
      default:          cur_param = '0;
    endcase
  end

  // Selected threshold entry; unused codes read zero
  always_comb begin
    sel_thr = '0;
    if (psel_valid) begin
      sel_thr = bsel ? thr_hi[psel] : thr_lo[psel];
    end
  end

  // Selector fields, stored from every write to the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psel        <= LQTA_PSEL_RESET;
      bsel        <= 1'b0;
      sample_mode <= 1'b0;
      data_field  <= LQTA_DATA_RESET;
    end else if (wr_hit) begin
      psel        <= wr_psel;
      bsel        <= wr_bsel;
      sample_mode <= req.wdata[LQTA_SAMPLE_BIT];
      data_field  <= req.wdata[DATA_W-1:0];
    end
  end

  // Sample capture; re-sampled each cycle while sample mode is held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled <= '0;
    end else if (sample_req || sample_mode) begin
      sampled <= cur_param;
    end
  end

  // Threshold store; write uses the selectors of the same write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LQTA_NUM_PARAMS; i++) begin
        thr_lo[i] <= LQTA_THR_LO_RESET;
        thr_hi[i] <= LQTA_THR_HI_RESET;
      end
    end else if (thr_we) begin
      if (wr_bsel) begin
        thr_hi[wr_psel] <= req.wdata[DATA_W-1:0];
      end else begin
        thr_lo[wr_psel] <= req.wdata[DATA_W-1:0];
      end
    end
  end

  // Strobe is never stored, only pulsed for one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_pulse <= 1'b0;
    end else begin
      write_pulse <= thr_we;
    end
  end

  // Read word built beside the bus so the flop only picks it up
  always_comb begin
    read_word = '0; // Top bits stay zero
    read_word[LQTA_SAMPLE_BIT]  = sample_mode;
    read_word[LQTA_WSTROBE_BIT] = LQTA_WSTROBE_READ;
    read_word[LQTA_PSEL_HI:LQTA_PSEL_LO] = psel;
    read_word[LQTA_BSEL_BIT]    = bsel;
    if (sample_mode) begin
      read_word[DATA_W-1:0] = sampled;
    end else begin
      read_word[DATA_W-1:0] = sel_thr;
    end
  end

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.rd && req.addr == LQTA_ADDR_ACCESS) begin
      rdata <= read_word;
    end else begin
      rdata <= '0; // Unmapped addresses read zero
    end
  end

  // Crossing check; full-scale thresholds can never be crossed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_event <= 1'b0;
    end else begin
      threshold_event <= monitor_enable && psel_valid &&
                         (sampled < thr_lo[psel] ||
                          sampled > thr_hi[psel]);
    end
  end

  // Assertions, one rule each, beside the logic above

  // Power-down swallows the strobe before it reaches the pulse
  pwrdn_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    powered_down |=> !write_pulse)
    else $error("threshold write while powered down");

  // Power-down also leaves the addressed low entry untouched
  pwrdn_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    powered_down && strobe_req && !wr_bsel && wr_psel < 3'h5
    |=> thr_lo[$past(wr_psel)] == $past(thr_lo[wr_psel]))
    else $error("threshold changed while powered down");

  // Reserved bits never show anything but zero
  rsvd_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdata[15:14] == 2'b00)
    else $error("reserved bits nonzero");

  // Trigger write captures the live parameter on its edge
  sample_value_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    sample_req |=> sampled == $past(cur_param))
    else $error("sample not captured");

  // Held sample mode keeps following the selected parameter
  sample_track_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    sample_mode |=> sampled == $past(cur_param))
    else $error("sample not tracking");

  // Sample mode returns the sample in the low byte
  sample_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == LQTA_ADDR_ACCESS && sample_mode
    |=> rdata[7:0] == $past(sampled))
    else $error("sample readback wrong");

  // Strobe bit reads the fixed constant whatever was written
  strobe_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdata[LQTA_WSTROBE_BIT] == LQTA_WSTROBE_READ)
    else $error("write strobe read not constant");

  // A pulse lasts one cycle unless a new write follows at once
  pulse_single_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    write_pulse |=> !write_pulse || $past(strobe_req))
    else $error("write pulse stretched");

  // No pulse without a strobe write in the cycle before
  pulse_cause_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    write_pulse |-> $past(strobe_req))
    else $error("write pulse without strobe");

  // Low entry takes the data byte of the same write
  thr_store_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    strobe_req && !powered_down && !wr_bsel && wr_psel < 3'h5
    |=> thr_lo[$past(wr_psel)] == $past(req.wdata[7:0]))
    else $error("low threshold not stored");

  // High entry takes the data byte of the same write
  thr_hi_store_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    strobe_req && !powered_down && wr_bsel && wr_psel < 3'h5
    |=> thr_hi[$past(wr_psel)] == $past(req.wdata[7:0]))
    else $error("high threshold not stored");

  // Codes without an entry give no pulse
  bad_code_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    strobe_req && wr_psel > 3'h4 |=> !write_pulse)
    else $error("pulse for unused selector code");

  // Every write to the register updates both selectors
  sel_follow_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_hit |=> psel == $past(wr_psel) && bsel == $past(wr_bsel))
    else $error("select fields not updated");

  // Selectors read back where they were written
  sel_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == LQTA_ADDR_ACCESS
    |=> rdata[11:8] == {$past(psel), $past(bsel)})
    else $error("selector readback wrong");

  // Threshold mode returns the addressed entry
  read_field_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == LQTA_ADDR_ACCESS && !sample_mode
    |=> rdata[7:0] == $past(sel_thr))
    else $error("threshold readback wrong");

  // Read data stand only in the cycle after a mapped read
  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(req.rd && req.addr == LQTA_ADDR_ACCESS) |=> rdata == 16'h0000)
    else $error("read data outside read cycle");

  // Monitor off keeps the event low
  event_mask_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !monitor_enable |=> !threshold_event)
    else $error("event while monitor off");

  // A sample under its low bound raises the event
  event_low_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    monitor_enable && psel_valid && sampled < thr_lo[psel]
    |=> threshold_event)
    else $error("low crossing missed");

  // Main scenarios worth seeing in coverage
  cov_write_c: cover property (@(posedge clk) disable iff (!rst_n)
    strobe_req && !powered_down);

  cov_blocked_c: cover property (@(posedge clk) disable iff (!rst_n)
    strobe_req && powered_down);

  cov_hi_write_c: cover property (@(posedge clk) disable iff (!rst_n)
    strobe_req && !powered_down && wr_bsel);

  cov_sample_c: cover property (@(posedge clk) disable iff (!rst_n)
    sample_req ##1 req.rd);

  cov_event_c: cover property (@(posedge clk) disable iff (!rst_n)
    threshold_event);
endmodule

// >>> test/lqta_tb.sv
// Self-checking bench for the threshold access register
module tb
  import lqta_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk            = 1'b0;
  logic         rst_n          = 1'b0;
  logic         powered_down   = 1'b0;
  logic         monitor_enable = 1'b0;
  lqta_req_t    req            = '0;
  lqta_params_t params         = '0;
  logic [15:0]  rdata;
  logic         threshold_event;
  logic         write_pulse;
  logic [15:0]  rv;
  int           fail_count      = 0;
  int           samples_checked = 0;
  int           cycles          = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  lqta_threshold_access dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .req             (req),
    .rdata           (rdata),
    .powered_down    (powered_down),
    .monitor_enable  (monitor_enable),
    .params          (params),
    .threshold_event (threshold_event),
    .write_pulse     (write_pulse)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One write cycle; strobe drops on the following edge, pulse checked then
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic p);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
    #1 chk({15'h0, write_pulse}, {15'h0, p});
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk) req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 v = rdata;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 120 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(LQTA_ADDR_ACCESS, rv); chk(rv, 16'h0000);
    wr(LQTA_ADDR_ACCESS, 16'h0100, 1'b0);
    rd(LQTA_ADDR_ACCESS, rv); chk(rv, 16'h01ff);
    // Every entry, with reserved bits set to prove they are dropped
    for (int k = 0; k < 10; k++) begin
      wr(LQTA_ADDR_ACCESS, {2'b11, 2'b01, k[3:0], 8'h30 + k[7:0]},
         1'b1);
      rd(LQTA_ADDR_ACCESS, rv);
      chk(rv, {4'h0, k[3:0], 8'h30 + k[7:0]});
    end
    // Powered down: store must keep its old byte
    @(posedge clk) powered_down <= 1'b1;
    wr(LQTA_ADDR_ACCESS, 16'h1277, 1'b0);
    @(posedge clk) powered_down <= 1'b0;
    rd(LQTA_ADDR_ACCESS, rv); chk(rv, 16'h0232);
    // Unused selector code has no entry behind it
    wr(LQTA_ADDR_ACCESS, 16'h1a77, 1'b0);
    rd(LQTA_ADDR_ACCESS, rv); chk(rv, 16'h0a00);
    // Sample each parameter in turn
    @(posedge clk) params <= {8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
    for (int k = 0; k < 5; k++) begin
      wr(LQTA_ADDR_ACCESS, {4'b0010, k[2:0], 9'h000}, 1'b0);
      rd(LQTA_ADDR_ACCESS, rv);
      chk(rv, {4'b0010, k[2:0], 1'b0, params[8*k +: 8]});
    end
    // Gain 0x22 sits below its low threshold 0x32
    @(posedge clk) monitor_enable <= 1'b1;
    wr(LQTA_ADDR_ACCESS, 16'h2200, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, threshold_event}, 16'h0001);
    // Equal to the bound is not a crossing
    @(posedge clk) params.dig_gain <= 8'h32;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, threshold_event}, 16'h0000);
    // Monitor off masks a real crossing
    @(posedge clk) params.dig_gain <= 8'h22;
    monitor_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, threshold_event}, 16'h0000);
    // Full-scale bounds switch the check off at both extremes
    wr(LQTA_ADDR_ACCESS, 16'h1800, 1'b1);
    wr(LQTA_ADDR_ACCESS, 16'h19ff, 1'b1);
    wr(LQTA_ADDR_ACCESS, 16'h2800, 1'b0);
    @(posedge clk) params.freq_ctrl <= 8'hff;
    monitor_enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, threshold_event}, 16'h0000);
    @(posedge clk) params.freq_ctrl <= 8'h00;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, threshold_event}, 16'h0000);
    rd(5'h1d, rv); chk(rv, 16'h0000);
    final_report();
  end
endmodule
